// >>> logic/wtb_filter.sv
// Noise filter for the capture source: the output follows only after
// LEN equal samples; when disabled it follows the input a cycle late.
// Assumes a synchronised input.
`timescale 1ns/1ps
`default_nettype none
`include "wtb_params.svh"
module wtb_filter #(
   parameter int LEN = `WTB_FILT_LEN
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic en,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic [LEN-1:0] hist;
      logic           out;
   } wtb_filt_t;

   wtb_filt_t q, d;

   if (LEN < 2 || LEN > 16)
   begin : g_chk
      $error("wtb_filter length must be 2 to 16.");
   end

   always_comb
   begin
      d = q;
      d.hist = {q.hist[LEN-2:0], din};
      if (!en)
         d.out = din;
      else if (&q.hist)
         d.out = 1'b1;
      else if (~|q.hist)
         d.out = 1'b0;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign dout = q.out;
endmodule // wtb_filter
`default_nettype wire

// >>> logic/wtb_params.svh
// Offsets, field positions, reset values and timing counts of the timer.
// Assumes an 8-bit classic Wishbone slave port with byte addresses.
`ifndef WTB_PARAMS_SVH
`define WTB_PARAMS_SVH

`define WTB_AW          4
`define WTB_ADR_CTRL_A  4'h0
`define WTB_ADR_CTRL_B  4'h1
`define WTB_ADR_CNT_L   4'h2
`define WTB_ADR_CNT_H   4'h3
`define WTB_ADR_CMPA_L  4'h4
`define WTB_ADR_CMPA_H  4'h5
`define WTB_ADR_CMPB_L  4'h6
`define WTB_ADR_CMPB_H  4'h7
`define WTB_ADR_CAPT_L  4'h8
`define WTB_ADR_CAPT_H  4'h9
`define WTB_ADR_FLAG    4'ha
`define WTB_ADR_MASK    4'hb

`define WTB_CA_FORCE_A  7
`define WTB_CA_FORCE_B  6
`define WTB_CB_FILT     7
`define WTB_CB_EDGE     6
`define WTB_CB_ACSEL    5
`define WTB_CB_WGM3     4
`define WTB_CB_WGM2     3

`define WTB_F_OVF       0
`define WTB_F_CMPA      1
`define WTB_F_CMPB      2
`define WTB_F_CAPT      3

`define WTB_RST_BYTE    8'h00
`define WTB_RST_WORD    16'h0000
`define WTB_BOTTOM      16'h0000
`define WTB_MAX         16'hffff
`define WTB_TOP_8BIT    16'h00ff
`define WTB_TOP_9BIT    16'h01ff
`define WTB_TOP_10BIT   16'h03ff

`define WTB_DIV8_MASK    10'h007
`define WTB_DIV64_MASK   10'h03f
`define WTB_DIV256_MASK  10'h0ff
`define WTB_DIV1024_MASK 10'h3ff

`define WTB_FILT_LEN    4

`endif

// >>> logic/wtb_pkg.sv
// Types shared by the timer modules.
// Assumes wtb_params.svh is on the include path.
package wtb_pkg;

   typedef enum logic [2:0] {
      cs_stop, cs_div1, cs_div8, cs_div64,
      cs_div256, cs_div1024, cs_ext_fall, cs_ext_rise
   } wtb_cs_t;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] cmpa_buf;
      logic [15:0] cmpb_buf;
      logic [15:0] cmpa_act;
      logic [15:0] cmpb_act;
      logic [15:0] capt;
      logic [7:0]  temp;
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [3:0]  flags;
      logic [3:0]  mask;
      logic [9:0]  presc;
      logic        ext_prev;
      logic        cap_prev;
      logic        pin_a;
      logic        pin_b;
      logic [3:0]  irq;
      logic        bottom;
      logic        max;
      logic        ack;
      logic [7:0]  dat;
   } wtb_state_t;

endpackage

// >>> logic/wtb_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes the inputs are levels that change slower than core_clk.
`timescale 1ns/1ps
`default_nettype none
module wtb_sync #(
   parameter int W = 3
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } wtb_sync_t;

   wtb_sync_t q, d;

   if (W < 1)
   begin : g_chk
      $error("wtb_sync needs at least one bit.");
   end

   always_comb
   begin
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign dout = q.s2;
endmodule // wtb_sync
`default_nettype wire

// >>> logic/wtb_timer.sv
// Sixteen-bit timer with byte-wide register access through a shared
// high-byte holding register, two compare channels and one capture unit.
// Assumes an 8-bit classic Wishbone master on core_clk.
//
// Behaviour
// - Count, both compares and capture are 16 bits, reached as byte halves.
// - One 8-bit holding register is shared by all 16-bit registers.
// - Low-byte write loads holding byte high and written byte low at once; capture only when it is top.
// - Count and capture low-byte reads copy the high half into the holding register.
// - Compare reads return bytes directly and leave the holding register.
// - Compare values are matched on each timer tick and drive compare pins.
// - A compare match sets that channel's match flag.
// - With no clock source selected the counter does not advance.
// - Tick comes from the prescaler or external pin with chosen edge.
// - Bottom is signalled when the counter becomes all zeros.
// - Max is signalled when the counter becomes all ones.
// - Top is a fixed value, compare A or capture, by mode.
// - Compare A as PWM top gives no PWM on A and is buffered.
// - Filtered capture edges copy the counter into the capture register.
// - Flags show every request, each gated by its own mask bit.
// - Control B is a plain direct 8-bit register; control A keeps bits 5:0 only.
// - Control A takes two force strobes that are not stored; control B holds mode bits 3:2.
// - A software counter write beats a clear or count in that cycle.
// - Capture flag is set in the cycle the capture value is loaded.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "wtb_params.svh"
module wtb_timer #(
   parameter int FILT_LEN = `WTB_FILT_LEN
) (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [`WTB_AW-1:0]  wb_adr_i,
   input  wire logic [7:0]          wb_dat_i,
   input  wire logic [0:0]          wb_sel_i,
   output logic                     wb_ack_o,
   output logic [7:0]               wb_dat_o,
   input  wire logic                external_count_pin,
   input  wire logic                capture_pin,
   input  wire logic                comparator_output,
   output logic                     compare_output_pin_a,
   output logic                     compare_output_pin_b,
   output logic [3:0]               int_req,
   output logic                     at_bottom,
   output logic                     at_max
);
   import wtb_pkg::*;

   wtb_state_t   q, d;
   logic [2:0]   syn;
   logic         filt;
   logic         take, wr, rd;
   logic         tick, wrap, pwm, top_capt, top_cmpa;
   logic         match_a, match_b, cap_ev, force_a, force_b;
   logic [3:0]   wgm;
   logic [15:0]  top, cnt_n;
   logic [7:0]   rdata;
   wtb_cs_t      cs;

   wtb_sync #(
      .W (3)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .din      ({external_count_pin, capture_pin, comparator_output}),
      .dout     (syn)
   );

   wtb_filter #(
      .LEN (FILT_LEN)
   ) u_filt (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .en       (q.ctrl_b[`WTB_CB_FILT]),
      .din      (q.ctrl_b[`WTB_CB_ACSEL] ? syn[0] : syn[1]),
      .dout     (filt)
   );

   assign take = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wr   = take & wb_we_i & wb_sel_i[0];
   assign rd   = take & ~wb_we_i;
   assign wgm  = {q.ctrl_b[`WTB_CB_WGM3:`WTB_CB_WGM2], q.ctrl_a[1:0]};
   assign cs   = wtb_cs_t'(q.ctrl_b[2:0]);

   // Top value, PWM class and which register defines top, per mode.
   always_comb
   begin
      top_capt = 1'b0;
      top_cmpa = 1'b0;
      pwm      = 1'b1;
      case (wgm)
         4'h1, 4'h5: top = `WTB_TOP_8BIT;
         4'h2, 4'h6: top = `WTB_TOP_9BIT;
         4'h3, 4'h7: top = `WTB_TOP_10BIT;
         4'h4:
         begin
            top = q.cmpa_act;
            pwm = 1'b0;
         end
         4'h9, 4'hb, 4'hf:
         begin
            top      = q.cmpa_act;
            top_cmpa = 1'b1;
         end
         4'hc:
         begin
            top      = q.capt;
            top_capt = 1'b1;
            pwm      = 1'b0;
         end
         4'h8, 4'ha, 4'he:
         begin
            top      = q.capt;
            top_capt = 1'b1;
         end
         default:
         begin
            top = `WTB_MAX;
            pwm = 1'b0;
         end
      endcase
   end

   // Timer tick from the prescaler or the external pin.
   always_comb
   begin
      case (cs)
         cs_stop:     tick = 1'b0;
         cs_div1:     tick = 1'b1;
         cs_div8:     tick = (q.presc & `WTB_DIV8_MASK) == `WTB_DIV8_MASK;
         cs_div64:    tick = (q.presc & `WTB_DIV64_MASK) == `WTB_DIV64_MASK;
         cs_div256:   tick = (q.presc & `WTB_DIV256_MASK) == `WTB_DIV256_MASK;
         cs_div1024:  tick = q.presc == `WTB_DIV1024_MASK;
         cs_ext_fall: tick = q.ext_prev & ~syn[2];
         cs_ext_rise: tick = ~q.ext_prev & syn[2];
         default:     tick = 1'b0;
      endcase
   end

   // Register read multiplexer.
   always_comb
   begin
      case (wb_adr_i)
         `WTB_ADR_CTRL_A: rdata = {2'b00, q.ctrl_a[5:0]};
         `WTB_ADR_CTRL_B: rdata = q.ctrl_b;
         `WTB_ADR_CNT_L:  rdata = q.count[7:0];
         `WTB_ADR_CNT_H:  rdata = q.temp;
         `WTB_ADR_CMPA_L: rdata = q.cmpa_buf[7:0];
         `WTB_ADR_CMPA_H: rdata = q.cmpa_buf[15:8];
         `WTB_ADR_CMPB_L: rdata = q.cmpb_buf[7:0];
         `WTB_ADR_CMPB_H: rdata = q.cmpb_buf[15:8];
         `WTB_ADR_CAPT_L: rdata = q.capt[7:0];
         `WTB_ADR_CAPT_H: rdata = q.temp;
         `WTB_ADR_FLAG:   rdata = {4'h0, q.flags};
         `WTB_ADR_MASK:   rdata = {4'h0, q.mask};
         default:         rdata = `WTB_RST_BYTE;
      endcase
   end

   assign wrap    = q.count == top;
   assign cnt_n   = wrap ? `WTB_BOTTOM : q.count + 16'h0001;
   assign match_a = tick && cnt_n == q.cmpa_act;
   assign match_b = tick && cnt_n == q.cmpb_act;
   assign cap_ev  = (q.cap_prev ^ filt)
                    && (filt == q.ctrl_b[`WTB_CB_EDGE]);
   assign force_a = wr && wb_adr_i == `WTB_ADR_CTRL_A
                    && wb_dat_i[`WTB_CA_FORCE_A] && !pwm;
   assign force_b = wr && wb_adr_i == `WTB_ADR_CTRL_A
                    && wb_dat_i[`WTB_CA_FORCE_B] && !pwm;

   always_comb
   begin
      d          = q;
      d.ack      = take;
      d.presc    = q.presc + 10'h001;
      d.ext_prev = syn[2];
      d.cap_prev = filt;
      d.bottom   = q.count == `WTB_BOTTOM;
      d.max      = q.count == `WTB_MAX;
      d.irq      = q.flags & q.mask;
      if (rd)
         d.dat = rdata;
      if (tick)
         d.count = cnt_n;
      if (!pwm || (tick && wrap))
      begin
         d.cmpa_act = q.cmpa_buf;
         d.cmpb_act = q.cmpb_buf;
      end
      if (pwm && !top_cmpa)
         d.pin_a = q.count < q.cmpa_act;
      else if (match_a || force_a)
         d.pin_a = ~q.pin_a;
      if (pwm)
         d.pin_b = q.count < q.cmpb_act;
      else if (match_b || force_b)
         d.pin_b = ~q.pin_b;
      if (rd && wb_adr_i == `WTB_ADR_CNT_L)
         d.temp = q.count[15:8];
      if (rd && wb_adr_i == `WTB_ADR_CAPT_L)
         d.temp = q.capt[15:8];
      if (wr)
      begin
         case (wb_adr_i)
            `WTB_ADR_CTRL_A: d.ctrl_a = {2'b00, wb_dat_i[5:0]};
            `WTB_ADR_CTRL_B: d.ctrl_b = wb_dat_i;
            `WTB_ADR_CNT_H, `WTB_ADR_CMPA_H, `WTB_ADR_CMPB_H,
            `WTB_ADR_CAPT_H: d.temp = wb_dat_i;
            `WTB_ADR_CNT_L:  d.count = {q.temp, wb_dat_i};
            `WTB_ADR_CMPA_L: d.cmpa_buf = {q.temp, wb_dat_i};
            `WTB_ADR_CMPB_L: d.cmpb_buf = {q.temp, wb_dat_i};
            `WTB_ADR_CAPT_L:
            begin
               if (top_capt)
                  d.capt = {q.temp, wb_dat_i};
            end
            `WTB_ADR_MASK:   d.mask = wb_dat_i[3:0];
            default:         d.dat = d.dat;
         endcase
      end
      if (wr && wb_adr_i == `WTB_ADR_FLAG)
         d.flags = q.flags & ~wb_dat_i[3:0];
      if (cap_ev)
      begin
         d.capt = q.count;
         d.flags[`WTB_F_CAPT] = 1'b1;
      end
      if (tick && wrap)
         d.flags[`WTB_F_OVF] = 1'b1;
      if (match_a)
         d.flags[`WTB_F_CMPA] = 1'b1;
      if (match_b)
         d.flags[`WTB_F_CMPB] = 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign wb_ack_o             = q.ack;
   assign wb_dat_o             = q.dat;
   assign compare_output_pin_a = q.pin_a;
   assign compare_output_pin_b = q.pin_b;
   assign int_req              = q.irq;
   assign at_bottom            = q.bottom;
   assign at_max               = q.max;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   lo_write_a: assert property (
      wr && wb_adr_i == `WTB_ADR_CNT_L
      |=> q.count == {$past(q.temp), $past(wb_dat_i)})
      else $error("Counter low write did not load both bytes.");

   lo_read_a: assert property (
      rd && wb_adr_i == `WTB_ADR_CNT_L
      |=> q.temp == $past(q.count[15:8]) ##1 !q.ack)
      else $error("Counter low read did not fill the holding byte.");

   cmp_read_a: assert property (
      rd && wb_adr_i inside {[`WTB_ADR_CMPA_L:`WTB_ADR_CMPB_H]}
      |=> $stable(q.temp)
          && wb_dat_o == $past(wb_adr_i[1]
             ? (wb_adr_i[0] ? q.cmpb_buf[15:8] : q.cmpb_buf[7:0])
             : (wb_adr_i[0] ? q.cmpa_buf[15:8] : q.cmpa_buf[7:0])))
      else $error("Compare read disturbed the holding byte.");

   hold_keep_a: assert property (
      !take && !cap_ev |=> $stable(q.temp))
      else $error("Holding byte changed without an access.");

   stop_count_a: assert property (
      cs == cs_stop && !wr |=> $stable(q.count))
      else $error("Counter moved with no clock source.");

   bottom_flag_a: assert property (
      q.count == `WTB_BOTTOM |=> at_bottom)
      else $error("Bottom not signalled at zero.");

   bottom_clear_a: assert property (
      q.count != `WTB_BOTTOM |=> !at_bottom)
      else $error("Bottom signalled away from zero.");

   max_flag_a: assert property (
      q.count == `WTB_MAX |=> at_max)
      else $error("Max not signalled at all ones.");

   max_clear_a: assert property (
      q.count != `WTB_MAX |=> !at_max)
      else $error("Max signalled away from all ones.");

   match_flag_a: assert property (
      match_a && !(wr && wb_adr_i == `WTB_ADR_CNT_L)
      |=> q.flags[`WTB_F_CMPA] && q.count == $past(q.cmpa_act))
      else $error("Compare match did not set its flag.");

   capt_flag_a: assert property (
      cap_ev |=> q.flags[`WTB_F_CAPT] && q.capt == $past(q.count))
      else $error("Capture flag not set with the capture load.");

   irq_gate_a: assert property (
      ##1 int_req == $past(q.flags & q.mask))
      else $error("Interrupt request not gated by its mask.");

   bus_ack_a: assert property (
      take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Bus answer not a single cycle.");

   max_wrap_a: assert property (
      wgm == 4'h0 && tick && q.count == `WTB_MAX && !wr
      |=> q.count == `WTB_BOTTOM && q.flags[`WTB_F_OVF])
      else $error("Normal mode did not wrap from all ones.");

   tick_only_a: assert property (
      !tick && !(wr && wb_adr_i == `WTB_ADR_CNT_L) |=> $stable(q.count))
      else $error("Counter moved without a timer tick.");

   ctrl_write_a: assert property (
      wr && wb_adr_i == `WTB_ADR_CTRL_B |=> q.ctrl_b == $past(wb_dat_i))
      else $error("Control B did not take the written byte.");

   force_pin_a: assert property (
      force_a |=> compare_output_pin_a != $past(compare_output_pin_a))
      else $error("Force bit did not toggle compare pin A.");

   hold_write_a: assert property (
      wr && wb_adr_i inside {`WTB_ADR_CNT_H, `WTB_ADR_CMPA_H,
                             `WTB_ADR_CMPB_H, `WTB_ADR_CAPT_H}
      |=> q.temp == $past(wb_dat_i))
      else $error("High byte write missed the holding byte.");

   flag_clear_a: assert property (
      wr && wb_adr_i == `WTB_ADR_FLAG && !tick && !cap_ev
      |=> (q.flags & $past(wb_dat_i[3:0])) == 4'h0)
      else $error("Writing one did not clear a flag.");

   capt_keep_a: assert property (
      !cap_ev && !(wr && wb_adr_i == `WTB_ADR_CAPT_L)
      |=> $stable(q.capt))
      else $error("Capture value changed without an event.");
endmodule // wtb_timer
`default_nettype wire

// >>> sim/test_wide_timer_byte_access.sv
// Self-checking bench for the byte-accessed sixteen-bit timer.
// Assumes wtb_timer and wtb_cpu_model compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "wtb_params.svh"
module test_wide_timer_byte_access;
   logic        core_clk, rst_n, ext_pin, cap_pin, cmp_out;
   logic        cyc, stb, we, ack, pin_a, pin_b, bot, mx;
   logic [3:0]  adr, irq;
   logic [7:0]  wdat, rdat, q;
   logic [0:0]  sel;
   logic [15:0] v, w;
   logic        pa, pb;
   int          err_total, n_compared, seed, n;

   wtb_cpu_model cpu_u (.core_clk(core_clk), .wb_cyc_o(cyc), .wb_stb_o(stb),
      .wb_we_o(we), .wb_adr_o(adr), .wb_dat_o(wdat), .wb_sel_o(sel),
      .wb_ack_i(ack), .wb_dat_i(rdat));

   wtb_timer #(.FILT_LEN(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(rdat),
      .external_count_pin(ext_pin), .capture_pin(cap_pin),
      .comparator_output(cmp_out), .compare_output_pin_a(pin_a),
      .compare_output_pin_b(pin_b), .int_req(irq), .at_bottom(bot),
      .at_max(mx));

   always #12.5 core_clk = ~core_clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Control A reads back its mode bits; the force bits always read zero.
   function automatic logic [7:0] ctrl_a_back(input logic [7:0] wv);
      return {2'b00, wv[5:0]};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cpu_u.access(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      cpu_u.access(1'b0, a, 8'h00, q);
      chk({8'h00, q}, {8'h00, e});
   endtask

   task automatic cycles(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   task automatic wrap_up;
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      #(25 * 30000);
      err_total++;
      wrap_up();
   end

   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      ext_pin = 1'b0;
      cap_pin = 1'b0;
      cmp_out = 1'b0;
      err_total = 0;
      n_compared = 0;
      seed = 32'heda7414b;
      cycles(2);
      rst_n <= 1'b1;
      for (int a = 0; a < 13; a++)
         rdchk(4'(a), 8'h00);
      wr(4'hc, 8'hff);
      rdchk(4'hc, 8'h00);
      v = 16'($random(seed));
      w = {8'h00, (v[7:0] & 8'h03) | 8'hc0};
      wr(`WTB_ADR_CTRL_A, w[7:0]);
      rdchk(`WTB_ADR_CTRL_A, ctrl_a_back(w[7:0]));
      wr(`WTB_ADR_CTRL_B, v[15:8] & 8'hf8);
      rdchk(`WTB_ADR_CTRL_B, v[15:8] & 8'hf8);
      wr(`WTB_ADR_CTRL_A, 8'h00);
      wr(`WTB_ADR_CTRL_B, 8'h00);
      pa = pin_a;
      pb = pin_b;
      wr(`WTB_ADR_CTRL_A, 8'hc0);
      chk({14'h0000, pin_a, pin_b}, {14'h0000, ~pa, ~pb});
      for (int i = 0; i < 5; i++)
      begin
         v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
         cpu_u.wr16(`WTB_ADR_CNT_L, v);
         cycles(3);
         cpu_u.rd16(`WTB_ADR_CNT_L, w);
         chk(w, v);
      end
      v = 16'($random(seed));
      wr(`WTB_ADR_CMPA_H, v[15:8]);
      wr(`WTB_ADR_CMPA_L, v[7:0]);
      wr(`WTB_ADR_CMPB_L, ~v[7:0]);
      cpu_u.rd16(`WTB_ADR_CMPA_L, w);
      chk(w, v);
      rdchk(`WTB_ADR_CMPB_H, v[15:8]);
      cpu_u.wr16(`WTB_ADR_CNT_L, 16'h1234);
      wr(`WTB_ADR_CMPA_H, 8'hee);
      rdchk(`WTB_ADR_CNT_L, 8'h34);
      rdchk(`WTB_ADR_CMPA_H, v[15:8]);
      rdchk(`WTB_ADR_CMPB_L, ~v[7:0]);
      rdchk(`WTB_ADR_CNT_H, 8'h12);
      cpu_u.wr16(`WTB_ADR_CNT_L, 16'hfff0);
      wr(`WTB_ADR_CTRL_B, 8'h01);
      n = 0;
      while (mx !== 1'b1 && n < 100)
      begin
         @(negedge core_clk);
         n++;
      end
      chk({15'h0000, mx}, 16'h0001);
      n = 0;
      while (bot !== 1'b1 && n < 100)
      begin
         @(negedge core_clk);
         n++;
      end
      chk({15'h0000, bot}, 16'h0001);
      wr(`WTB_ADR_CTRL_B, 8'h00);
      cpu_u.wr16(`WTB_ADR_CMPA_L, 16'h0110);
      cpu_u.wr16(`WTB_ADR_CMPB_L, 16'h0120);
      cpu_u.wr16(`WTB_ADR_CNT_L, 16'h0100);
      wr(`WTB_ADR_FLAG, 8'h0f);
      wr(`WTB_ADR_MASK, 8'h06);
      pa = pin_a;
      pb = pin_b;
      wr(`WTB_ADR_CTRL_B, 8'h01);
      cycles(60);
      wr(`WTB_ADR_CTRL_B, 8'h00);
      chk({14'h0000, pin_a, pin_b}, {14'h0000, ~pa, ~pb});
      rdchk(`WTB_ADR_FLAG, 8'h06);
      @(negedge core_clk);
      chk({12'h000, irq}, 16'h0006);
      wr(`WTB_ADR_MASK, 8'h02);
      cycles(2);
      @(negedge core_clk);
      chk({12'h000, irq}, 16'h0002);
      wr(`WTB_ADR_FLAG, 8'h06);
      rdchk(`WTB_ADR_FLAG, 8'h00);
      wr(`WTB_ADR_MASK, 8'h00);
      for (int c = 6; c < 8; c++)
      begin
         n = 3 + ($unsigned($random(seed)) % 6);
         cpu_u.wr16(`WTB_ADR_CNT_L, 16'h0000);
         wr(`WTB_ADR_CTRL_B, c[7:0]);
         repeat (n)
         begin
            ext_pin <= 1'b1;
            cycles(4);
            ext_pin <= 1'b0;
            cycles(4);
         end
         cycles(6);
         wr(`WTB_ADR_CTRL_B, 8'h00);
         cpu_u.rd16(`WTB_ADR_CNT_L, w);
         chk(w, n[15:0]);
      end
      for (int k = 0; k < 2; k++)
      begin
         v = 16'($random(seed));
         cpu_u.wr16(`WTB_ADR_CNT_L, v);
         wr(`WTB_ADR_CTRL_B, (k == 1) ? 8'he0 : 8'h40);
         if (k == 1)
         begin
            cmp_out <= 1'b1;
            cycles(2);
            cmp_out <= 1'b0;
            cycles(20);
            rdchk(`WTB_ADR_FLAG, 8'h00);
         end
         if (k == 1)
            cmp_out <= 1'b1;
         else
            cap_pin <= 1'b1;
         cycles(20);
         cpu_u.rd16(`WTB_ADR_CAPT_L, w);
         chk(w, v);
         rdchk(`WTB_ADR_FLAG, 8'h08);
         wr(`WTB_ADR_FLAG, 8'h08);
         cap_pin <= 1'b0;
         cmp_out <= 1'b0;
         cycles(20);
      end
      wrap_up();
   end
endmodule // test_wide_timer_byte_access
`default_nettype wire

// >>> sim/wtb_cpu_model.sv
// Classic Wishbone master standing in for the CPU core of the timer.
// Assumes an 8-bit slave on core_clk that answers every request with ack.
`timescale 1ns/1ps
`default_nettype none
`include "wtb_params.svh"
module wtb_cpu_model (
   input  wire logic               core_clk,
   output logic                    wb_cyc_o,
   output logic                    wb_stb_o,
   output logic                    wb_we_o,
   output logic [`WTB_AW-1:0]      wb_adr_o,
   output logic [7:0]              wb_dat_o,
   output logic [0:0]              wb_sel_o,
   input  wire logic               wb_ack_i,
   input  wire logic [7:0]         wb_dat_i
);
   initial
   begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = '0;
      wb_dat_o = 8'h00;
      wb_sel_o = 1'b1;
   end

   // One request, held until ack is seen; data lines scrambled when idle.
   task automatic access(input logic w, input logic [`WTB_AW-1:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= w;
      wb_sel_o <= 1'b1;
      wb_adr_o <= a;
      wb_dat_o <= d;
      do @(posedge core_clk); while (wb_ack_i !== 1'b1);
      q = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
      wb_dat_o <= ~d;
   endtask

   // Two-byte accesses never interleave with any other access.
   task automatic wr16(input logic [`WTB_AW-1:0] a, input logic [15:0] v);
      logic [7:0] q;
      access(1'b1, a + 4'h1, v[15:8], q);
      access(1'b1, a, v[7:0], q);
   endtask

   task automatic rd16(input logic [`WTB_AW-1:0] a, output logic [15:0] v);
      access(1'b0, a, 8'h00, v[7:0]);
      access(1'b0, a + 4'h1, 8'h00, v[15:8]);
   endtask
endmodule // wtb_cpu_model
`default_nettype wire
